// *** verilog/cks_clock_ctrl.sv ***
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Old clock cycle finishes to its rise
// - Output held high until new rises
// - New source starts with full high
// - Step field picks one of eight
// - Modulation count sets higher-step cycles
// - Remaining window cycles use selected step
// - No modulation at step seven
// - Second crystal off only when unused
// - Range select picks sixteen ranges
// - Zero is the lowest range
// - External resistor ignores range top bit
// - Control one resets to 87h
// - Modulation count zero disables modulation
// - Resistor bit picks internal or external
module cks_clock_ctrl (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic power_up_clear_in,
    input wire logic [8:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic digital_osc_clock_in,
    input wire logic second_crystal_osc_in,
    input wire logic low_freq_crystal_osc_in,
    output logic main_clock_out,
    output logic sub_main_clock_out,
    output logic aux_clock_out,
    output logic [2:0] osc_step_select_out,
    output logic [3:0] range_select_out,
    output logic external_resistor_select_out,
    output logic second_crystal_off_out,
    output logic low_crystal_mode_select_out,
    output logic [7:0] clock_control_three_out
);
    // Software registers
    logic [7:0] osc_tuning_reg; // Step and modulation count
    logic [7:0] clock_control_one_reg; // Crystal off, mode, aux divider, range
    logic [7:0] clock_control_two_reg; // Source selects, resistor bit
    logic [7:0] clock_control_three_reg; // Held for other logic
    logic [7:0] irq_enable_one_reg; // Plain storage
    logic [7:0] irq_flag_one_reg; // Plain storage

    // Bus side
    logic ack_reg; // Bus answer phase
    logic [31:0] rdata_reg; // Registered read data
    logic [6:0] idx; // Word index of the access
    logic wr_lane0; // Write touching the data byte
    logic [7:0] rd_mux; // Read value before the register

    // Clock switches
    logic [2:0] srcs; // Sampled source levels
    logic [1:0] main_sel; // Requested main source
    logic [1:0] sub_sel; // Requested sub-main source
    logic [1:0] main_cur; // Main source in use
    logic [1:0] sub_cur; // Sub-main source in use
    logic main_busy; // Main switch in progress
    logic sub_busy; // Sub-main switch in progress

    // Modulator and divider
    logic dco_prev_reg; // Oscillator level last cycle
    logic lf_prev_reg; // Crystal level last cycle
    logic [4:0] mod_cnt_reg; // Position in the 32-cycle window
    logic [2:0] step_reg; // Step in effect this cycle
    logic [2:0] aux_cnt_reg; // Crystal edge counter
    logic aux_reg; // Divided aux clock

    // Register fields
    logic [2:0] step_field; // Software step
    logic [4:0] mod_field; // Software modulation count
    logic [1:0] aux_div; // Software aux divider code
    logic ext_res; // Resistor select bit

    // Bus decode
    assign idx = avs_address_in[8:2];
    assign wr_lane0 = avs_write_in && avs_byteenable_in[0] && !ack_reg;

    // Field views
    assign step_field = osc_tuning_reg[cks_pkg::STEP_LSB +: 3];
    assign mod_field = osc_tuning_reg[cks_pkg::MOD_MSB:0];
    assign aux_div = clock_control_one_reg[cks_pkg::AUX_DIV_LSB +: 2];
    assign ext_res = clock_control_two_reg[cks_pkg::EXT_RES_BIT];

    // Sources and selects
    assign srcs = {low_freq_crystal_osc_in, second_crystal_osc_in, digital_osc_clock_in};
    assign main_sel = cks_pkg::main_src(clock_control_two_reg[cks_pkg::MAIN_SEL_LSB +: 2]);
    assign sub_sel = clock_control_two_reg[cks_pkg::SUB_SEL_BIT] ? cks_pkg::SRC_XT2 : cks_pkg::SRC_DCO;

    // Bus answers one cycle after a request is seen, then drops wait
    assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack_reg;
    assign avs_readdata_out = rdata_reg;

    // Answer phase toggles so each request is taken exactly once
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            ack_reg <= 1'b0;
        end else begin
            // High on the answer cycle, low again after it
            ack_reg <= (avs_read_in || avs_write_in) && !ack_reg;
        end
    end

    // Read decode; unmapped words read as zero
    always_comb begin
        case (idx)
            cks_pkg::IDX_IRQ_ENABLE_ONE: rd_mux = irq_enable_one_reg;
            cks_pkg::IDX_IRQ_FLAG_ONE: rd_mux = irq_flag_one_reg;
            cks_pkg::IDX_CLOCK_CONTROL_THREE: rd_mux = clock_control_three_reg;
            cks_pkg::IDX_OSC_TUNING: rd_mux = osc_tuning_reg;
            cks_pkg::IDX_CLOCK_CONTROL_ONE: rd_mux = clock_control_one_reg;
            cks_pkg::IDX_CLOCK_CONTROL_TWO: rd_mux = clock_control_two_reg;
            cks_pkg::IDX_CLOCK_STATUS: rd_mux = {sub_busy, main_busy, sub_cur, main_cur, step_reg[1:0]};
            default: rd_mux = 8'h00;
        endcase
    end

    // Read data captured while waitrequest is high
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            rdata_reg <= 32'h0000_0000;
        end else if (avs_read_in && !ack_reg) begin
            // Taken once per read
            rdata_reg <= {24'h00_0000, rd_mux};
        end
    end

    // Control one: power-on value; power-up clear resets only the range
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            clock_control_one_reg <= cks_pkg::RST_CLOCK_CONTROL_ONE;
        end else if (power_up_clear_in) begin
            // Other bits survive
            clock_control_one_reg[3:0] <= cks_pkg::PUC_RANGE_SELECT;
        end else if (wr_lane0 && idx == cks_pkg::IDX_CLOCK_CONTROL_ONE) begin
            clock_control_one_reg <= avs_writedata_in[7:0];
        end
    end

    // Registers reset to their PUC values by power-up clear as well as power-on reset
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in || power_up_clear_in) begin
            osc_tuning_reg <= cks_pkg::PUC_OSC_TUNING;
            clock_control_two_reg <= cks_pkg::PUC_CLOCK_CONTROL_TWO;
            clock_control_three_reg <= cks_pkg::PUC_CLOCK_CONTROL_THREE;
            irq_enable_one_reg <= cks_pkg::PUC_IRQ;
            irq_flag_one_reg <= cks_pkg::PUC_IRQ;
        end else if (wr_lane0) begin
            case (idx)
                cks_pkg::IDX_OSC_TUNING: osc_tuning_reg <= avs_writedata_in[7:0];
                cks_pkg::IDX_CLOCK_CONTROL_TWO: clock_control_two_reg <= avs_writedata_in[7:0];
                cks_pkg::IDX_CLOCK_CONTROL_THREE: clock_control_three_reg <= avs_writedata_in[7:0];
                cks_pkg::IDX_IRQ_ENABLE_ONE: irq_enable_one_reg <= avs_writedata_in[7:0];
                cks_pkg::IDX_IRQ_FLAG_ONE: irq_flag_one_reg <= avs_writedata_in[7:0];
                default: ;
            endcase
        end
    end

    // Edge history of the oscillator and the crystal
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            dco_prev_reg <= 1'b0;
            lf_prev_reg <= 1'b0;
        end else begin
            dco_prev_reg <= digital_osc_clock_in;
            lf_prev_reg <= low_freq_crystal_osc_in;
        end
    end

    // Modulator: first mod_field cycles of each 32 use the next step.
    // Changing the fields mid-window takes effect at once; the window
    // position is not restarted, which keeps the error bounded anyway.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            mod_cnt_reg <= 5'h00;
            step_reg <= cks_pkg::PUC_OSC_TUNING[cks_pkg::STEP_LSB +: 3];
        end else if (digital_osc_clock_in && !dco_prev_reg) begin
            mod_cnt_reg <= mod_cnt_reg + 5'h01; // Wraps every 32 cycles
            // Early window cycles step up
            if (step_field != cks_pkg::STEP_TOP && mod_cnt_reg < mod_field) begin
                step_reg <= step_field + 3'h1;
            end else begin
                step_reg <= step_field; // 32 minus count, or no modulation
            end
        end
    end

    // Aux divider on the low-frequency crystal clock
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            aux_cnt_reg <= 3'h0;
            aux_reg <= 1'b0;
        end else begin
            // Count crystal rises
            if (low_freq_crystal_osc_in && !lf_prev_reg) begin
                aux_cnt_reg <= aux_cnt_reg + 3'h1;
            end
            if (aux_div == 2'h0) begin
                aux_reg <= low_freq_crystal_osc_in;
            end else begin
                aux_reg <= aux_cnt_reg[aux_div - 2'h1]; // Bit n toggles every 2^n edges
            end
        end
    end

    // Main clock switch
    cks_clk_switch u_main_switch (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .src_in(srcs),
        .sel_in(main_sel),
        .clk_out(main_clock_out),
        .cur_sel_out(main_cur),
        .busy_out(main_busy)
    );

    // Sub-main clock switch
    cks_clk_switch u_sub_switch (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .src_in(srcs),
        .sel_in(sub_sel),
        .clk_out(sub_main_clock_out),
        .cur_sel_out(sub_cur),
        .busy_out(sub_busy)
    );

    // Oscillator controls; the crystal stays on while anything uses it
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            second_crystal_off_out <= 1'b0;
            range_select_out <= 4'h0;
            external_resistor_select_out <= 1'b0;
            low_crystal_mode_select_out <= 1'b0;
            osc_step_select_out <= 3'h0;
            aux_clock_out <= 1'b0;
            clock_control_three_out <= 8'h00;
        end else begin
            // Pending selects keep it on
            second_crystal_off_out <= clock_control_one_reg[cks_pkg::XT2_OFF_BIT]
                && main_cur != cks_pkg::SRC_XT2 && main_sel != cks_pkg::SRC_XT2
                && sub_cur != cks_pkg::SRC_XT2 && sub_sel != cks_pkg::SRC_XT2;
            // Top range bit dropped under the external resistor
            range_select_out <= {clock_control_one_reg[cks_pkg::RANGE_MSB_BIT] && !ext_res,
                                 clock_control_one_reg[2:0]};
            external_resistor_select_out <= ext_res;
            low_crystal_mode_select_out <= clock_control_one_reg[cks_pkg::LF_MODE_BIT];
            osc_step_select_out <= step_reg;
            aux_clock_out <= aux_reg;
            clock_control_three_out <= clock_control_three_reg;
        end
    end

    // Control one power-on value
    property p_por_value;
        @(posedge clk_sys_in) !rst_n_in |=> clock_control_one_reg == cks_pkg::RST_CLOCK_CONTROL_ONE;
    endproperty
    a_por_value: assert property (p_por_value) else $error("control one reset value wrong");

    // No step above the top
    property p_step_top;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (step_field == cks_pkg::STEP_TOP && digital_osc_clock_in && !dco_prev_reg)
        |=> step_reg == cks_pkg::STEP_TOP;
    endproperty
    a_step_top: assert property (p_step_top) else $error("modulation active at top step");

    // Count zero: no step up
    property p_mod_zero;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (mod_field == 5'h00 && digital_osc_clock_in && !dco_prev_reg)
        |=> step_reg == $past(step_field);
    endproperty
    a_mod_zero: assert property (p_mod_zero) else $error("modulation with zero count");

    // Claimed cycles step up
    property p_mod_high;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (step_field < 3'h7 && mod_cnt_reg < mod_field && digital_osc_clock_in && !dco_prev_reg)
        |=> step_reg == $past(step_field) + 3'h1;
    endproperty
    a_mod_high: assert property (p_mod_high) else $error("higher step not used");

    // Rest keep the step
    property p_mod_low;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (mod_cnt_reg >= mod_field && digital_osc_clock_in && !dco_prev_reg)
        |=> step_reg == $past(step_field);
    endproperty
    a_mod_low: assert property (p_mod_low) else $error("selected step not used");

    // Used crystal stays on
    property p_xt2_in_use;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (main_cur == cks_pkg::SRC_XT2 || sub_cur == cks_pkg::SRC_XT2)
        |=> !second_crystal_off_out;
    endproperty
    a_xt2_in_use: assert property (p_xt2_in_use) else $error("crystal stopped while in use");

    // Top range bit dropped
    property p_range_msb;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        ext_res |=> !range_select_out[3];
    endproperty
    a_range_msb: assert property (p_range_msb) else $error("range top bit not ignored");

    // Range passes through
    property p_range_pass;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        rst_n_in && !ext_res
        |=> range_select_out == $past(clock_control_one_reg[3:0]);
    endproperty
    a_range_pass: assert property (p_range_pass) else $error("range select not passed");

    // Divide by one
    property p_aux_div1;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        rst_n_in && aux_div == 2'h0
        |=> ##1 aux_clock_out == $past(low_freq_crystal_osc_in, 2);
    endproperty
    a_aux_div1: assert property (p_aux_div1) else $error("aux divide by one wrong");

    // Mode bit passes through
    property p_lf_mode;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        rst_n_in |=> low_crystal_mode_select_out == $past(clock_control_one_reg[6]);
    endproperty
    a_lf_mode: assert property (p_lf_mode) else $error("crystal mode not followed");

    // Main scenarios
    c_main_busy: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in) $fell(main_busy));
    c_sub_xt2: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in) sub_cur == cks_pkg::SRC_XT2);
    c_mod_step: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in) step_reg != step_field);
    c_write: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in) avs_write_in && !avs_waitrequest_out);
endmodule
`default_nettype wire

// *** pkg/cks_pkg.sv ***
package cks_pkg;
    // Register indices; byte address is four times the index
    localparam logic [6:0] IDX_IRQ_ENABLE_ONE = 7'h00;
    localparam logic [6:0] IDX_IRQ_FLAG_ONE = 7'h02;
    localparam logic [6:0] IDX_CLOCK_CONTROL_THREE = 7'h53;
    localparam logic [6:0] IDX_OSC_TUNING = 7'h56;
    localparam logic [6:0] IDX_CLOCK_CONTROL_ONE = 7'h57;
    localparam logic [6:0] IDX_CLOCK_CONTROL_TWO = 7'h58;
    localparam logic [6:0] IDX_CLOCK_STATUS = 7'h59;
    // Values after power-on reset and after power-up clear
    localparam logic [7:0] RST_CLOCK_CONTROL_ONE = 8'h87;
    localparam logic [3:0] PUC_RANGE_SELECT = 4'h7;
    localparam logic [7:0] PUC_OSC_TUNING = 8'h60;
    localparam logic [7:0] PUC_CLOCK_CONTROL_TWO = 8'h00;
    localparam logic [7:0] PUC_CLOCK_CONTROL_THREE = 8'h05;
    localparam logic [7:0] PUC_IRQ = 8'h00;
    // Field positions
    localparam int STEP_LSB = 5;
    localparam int MOD_MSB = 4;
    localparam int XT2_OFF_BIT = 7;
    localparam int LF_MODE_BIT = 6;
    localparam int AUX_DIV_LSB = 4;
    localparam int RANGE_MSB_BIT = 3;
    localparam int MAIN_SEL_LSB = 6;
    localparam int SUB_SEL_BIT = 3;
    localparam int EXT_RES_BIT = 0;
    // Highest oscillator step; modulation is void there
    localparam logic [2:0] STEP_TOP = 3'h7;
    // Source indices at the clock switches
    localparam logic [1:0] SRC_DCO = 2'h0;
    localparam logic [1:0] SRC_XT2 = 2'h1;
    localparam logic [1:0] SRC_LF = 2'h2;
    // Clock switch states
    typedef enum logic [1:0] {
        SW_RUN = 2'b00,
        SW_FINISH = 2'b01,
        SW_HOLD = 2'b10
    } cks_sw_state_t;
    // Main clock select code to source index
    function automatic logic [1:0] main_src(input logic [1:0] code);
        case (code)
            2'h2: main_src = SRC_XT2;
            2'h3: main_src = SRC_LF;
            default: main_src = SRC_DCO;
        endcase
    endfunction
endpackage

// *** verilog/cks_clk_switch.sv ***
`timescale 1ns/100ps
`default_nettype none
// Glitch-free switch among three sampled clock sources
module cks_clk_switch (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic [2:0] src_in,
    input wire logic [1:0] sel_in,
    output logic clk_out,
    output logic [1:0] cur_sel_out,
    output logic busy_out
);
    cks_pkg::cks_sw_state_t state_reg; // Switch sequence state
    logic [2:0] prev_reg; // Source levels one cycle ago
    logic [1:0] cur_reg; // Source now driving the output
    logic [1:0] new_reg; // Source being switched to
    logic clk_reg; // Output clock level
    logic [2:0] rise; // Rising edge of each source

    assign rise = src_in & ~prev_reg;
    assign clk_out = clk_reg;
    assign cur_sel_out = cur_reg;
    assign busy_out = (state_reg != cks_pkg::SW_RUN);

    // Edge history
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            prev_reg <= 3'h0;
        end else begin
            prev_reg <= src_in;
        end
    end

    // Switch sequence; a new request is only looked at in run state
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            state_reg <= cks_pkg::SW_RUN;
            cur_reg <= cks_pkg::SRC_DCO;
            new_reg <= cks_pkg::SRC_DCO;
            clk_reg <= 1'b0;
        end else begin
            case (state_reg)
                cks_pkg::SW_RUN: begin
                    clk_reg <= src_in[cur_reg];
                    if (sel_in != cur_reg) begin
                        new_reg <= sel_in;
                        state_reg <= cks_pkg::SW_FINISH;
                    end
                end
                cks_pkg::SW_FINISH: begin
                    // Old cycle runs to the old source's next rise
                    clk_reg <= src_in[cur_reg];
                    if (rise[cur_reg]) begin
                        state_reg <= cks_pkg::SW_HOLD;
                    end
                end
                cks_pkg::SW_HOLD: begin
                    // Held high until the new source rises
                    clk_reg <= 1'b1;
                    if (rise[new_reg]) begin
                        // New source takes over on its high phase
                        cur_reg <= new_reg;
                        state_reg <= cks_pkg::SW_RUN;
                    end
                end
                default: begin
                    state_reg <= cks_pkg::SW_RUN;
                end
            endcase
        end
    end

    property p_finish_rise;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (state_reg == cks_pkg::SW_FINISH && rise[cur_reg]) |=> (state_reg == cks_pkg::SW_HOLD) && clk_reg;
    endproperty
    a_finish_rise: assert property (p_finish_rise) else $error("old source rise did not enter hold");

    property p_hold_high;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (state_reg == cks_pkg::SW_HOLD) |=> clk_reg;
    endproperty
    a_hold_high: assert property (p_hold_high) else $error("output fell during hold");

    property p_new_source;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (state_reg == cks_pkg::SW_HOLD && rise[new_reg]) |=> (cur_reg == $past(new_reg)) ##1 (clk_reg == $past(src_in[cur_reg]));
    endproperty
    a_new_source: assert property (p_new_source) else $error("new source not routed");

    c_switch_done: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        state_reg == cks_pkg::SW_HOLD ##1 state_reg == cks_pkg::SW_RUN);
endmodule
`default_nettype wire

// *** tb/cks_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb;
    // One expected result: which output to look at and its value
    typedef struct packed {logic [3:0] sel; logic [31:0] exp;} cks_note_t;
    logic clk = 1'b0, rst_n = 1'b0, power_up_clear = 1'b0, rd = 1'b0, wrq = 1'b0, req = 1'b0;
    logic [8:0] adr = 9'h000;
    logic [31:0] wd = 32'h0, rdat, meas = 32'h0, seed = 32'h1d, v;
    logic [3:0] be = 4'h1, rng;
    logic [2:0] src = 3'h0; // Osc, second crystal, low crystal levels
    logic [2:0] stp;
    logic wt, mclk, sclk, aclk, xres, xoff, lfm;
    logic [7:0] c3;
    int half [3] = '{3, 5, 7}; // Half periods in clocks, all slower than clk/2
    int ph [3] = '{0, 0, 0};
    int bad_count = 0, total_checks = 0;
    cks_note_t notes [$];
    cks_clock_ctrl cks_clock_ctrl_inst (.clk_sys_in(clk), .rst_n_in(rst_n), .power_up_clear_in(power_up_clear),
        .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wrq), .avs_writedata_in(wd),
        .avs_byteenable_in(be), .avs_readdata_out(rdat), .avs_waitrequest_out(wt),
        .digital_osc_clock_in(src[0]), .second_crystal_osc_in(src[1]), .low_freq_crystal_osc_in(src[2]),
        .main_clock_out(mclk), .sub_main_clock_out(sclk), .aux_clock_out(aclk),
        .osc_step_select_out(stp), .range_select_out(rng), .external_resistor_select_out(xres),
        .second_crystal_off_out(xoff), .low_crystal_mode_select_out(lfm), .clock_control_three_out(c3));
    // System clock, 8 ns period
    always #4 clk = ~clk;
    // Source clocks run free, changed on the rising edge like any input
    always @(posedge clk) begin
        for (int i = 0; i < 3; i++) begin
            ph[i] <= (ph[i] == half[i] - 1) ? 0 : ph[i] + 1;
            if (ph[i] == half[i] - 1) src[i] <= ~src[i];
        end
    end
    // Xorshift source of stimulus values
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Output selected by a note
    function automatic logic [31:0] pick(input logic [3:0] s);
        case (s)
            4'h0: pick = rdat;
            4'h1: pick = {28'h0, rng};
            4'h2: pick = {31'h0, xoff};
            4'h3: pick = {31'h0, lfm};
            4'h4: pick = {31'h0, xres};
            4'h5: pick = {24'h0, c3};
            default: pick = meas;
        endcase
    endfunction
    function automatic logic lvl(input int s);
        return s == 0 ? mclk : (s == 1 ? sclk : aclk);
    endfunction
    // Watcher: at mid-cycle, so nothing races the edge updates
    always @(negedge clk) begin
        cks_note_t n;
        if ((rd === 1'b1 && wt === 1'b0) || req) begin
            n = notes.pop_front();
            total_checks++;
            if (pick(n.sel) !== n.exp) begin
                bad_count++;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, pick(n.sel), n.exp);
            end
        end
    end
    task automatic test_done;
        $display("checks=%0d mismatches=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Avalon transfer; waitrequest seen at mid-cycle equals its value at the next edge
    task automatic bus(input logic w, input logic [6:0] idx, input logic [7:0] d);
        logic ws;
        int k;
        @(posedge clk);
        adr <= {idx, 2'b00};
        wd <= {rnd() & 32'hffffff00} | {24'h0, d}; // Upper lanes carry noise on purpose
        wrq <= w;
        rd <= ~w;
        k = 0;
        do begin
            @(negedge clk);
            ws = wt;
            k++;
            @(posedge clk);
        end while (ws !== 1'b0 && k < 50);
        wrq <= 1'b0;
        rd <= 1'b0;
        if (k >= 50) begin
            bad_count++;
            test_done();
        end
    endtask
    task automatic put(input logic [6:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask
    task automatic get(input logic [6:0] idx, input logic [7:0] e);
        notes.push_back({4'h0, 24'h0, e});
        bus(1'b0, idx, 8'h00);
    endtask
    task automatic chk(input logic [3:0] s, input logic [31:0] e);
        notes.push_back({s, e});
        @(posedge clk);
        req <= 1'b1;
        @(posedge clk);
        req <= 1'b0;
    endtask
    // Clocks from one rise of a clock output to its next
    task automatic per(input int s);
        logic p;
        int r;
        repeat (30) @(negedge clk);
        p = lvl(s);
        r = 0;
        meas = 0;
        for (int k = 0; k < 400 && r < 2; k++) begin
            @(negedge clk);
            if (lvl(s) === 1'b1 && p === 1'b0) r++;
            if (r == 1) meas++;
            p = lvl(s);
        end
    endtask
    // meas ends at 1 if no later phase is under 3 clocks
    task automatic wid(input int s);
        logic p;
        int run, ch;
        p = lvl(s);
        run = 0;
        ch = 0;
        meas = 1;
        repeat (60) begin
            @(negedge clk);
            run++;
            if (lvl(s) !== p) begin
                if (ch > 0 && run < 3) meas = 0;
                ch++;
                run = 0;
                p = lvl(s);
            end
        end
    endtask
    // One sample per oscillator period over one 32-period window
    task automatic modu(input logic [2:0] s, input logic [4:0] m);
        int hi, lo;
        put(cks_pkg::IDX_OSC_TUNING, {s, m});
        repeat (400) @(posedge clk); // Two windows, so the new setting is in force
        hi = 0;
        lo = 0;
        repeat (32) begin
            repeat (6) @(negedge clk);
            if (s != 3'h7 && stp === s + 3'h1) hi++;
            else if (stp === s) lo++;
        end
        meas = hi;
        chk(4'h6, (s == 3'h7) ? 0 : m);
        meas = lo;
        chk(4'h6, (s == 3'h7) ? 32 : 32 - m);
    endtask
    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        get(cks_pkg::IDX_CLOCK_CONTROL_ONE, 8'h87);
        get(cks_pkg::IDX_OSC_TUNING, 8'h60);
        get(cks_pkg::IDX_CLOCK_CONTROL_THREE, 8'h05);
        get(cks_pkg::IDX_CLOCK_CONTROL_TWO, 8'h00);
        get(7'h01, 8'h00);
        $display("reset values done");
        v = rnd();
        put(cks_pkg::IDX_IRQ_ENABLE_ONE, v[7:0]);
        get(cks_pkg::IDX_IRQ_ENABLE_ONE, v[7:0]);
        put(cks_pkg::IDX_IRQ_FLAG_ONE, v[15:8]);
        get(cks_pkg::IDX_IRQ_FLAG_ONE, v[15:8]);
        put(cks_pkg::IDX_CLOCK_CONTROL_THREE, v[23:16]);
        put(7'h01, 8'ha5); // Unmapped place ignores writes
        get(7'h01, 8'h00);
        be <= 4'h0;
        put(cks_pkg::IDX_CLOCK_CONTROL_THREE, ~v[23:16]);
        be <= 4'h1;
        get(cks_pkg::IDX_CLOCK_CONTROL_THREE, v[23:16]);
        chk(4'h5, {24'h0, v[23:16]});
        $display("register access done");
        for (int r = 0; r < 16; r++) begin
            v = rnd();
            put(cks_pkg::IDX_CLOCK_CONTROL_TWO, {7'h0, v[0]});
            put(cks_pkg::IDX_CLOCK_CONTROL_ONE, {v[7:4], r[3:0]});
            repeat (2) @(posedge clk);
            chk(4'h1, v[0] ? r & 7 : r);
            chk(4'h4, {31'h0, v[0]});
            chk(4'h3, {31'h0, v[6]});
            chk(4'h2, {31'h0, v[7]});
        end
        $display("range and mode done");
        for (int d = 0; d < 4; d++) begin
            put(cks_pkg::IDX_CLOCK_CONTROL_ONE, {2'b10, d[1:0], 4'h7});
            per(2);
            chk(4'h6, 14 << d);
        end
        $display("aux divider done");
        put(cks_pkg::IDX_CLOCK_CONTROL_TWO, 8'hc0);
        wid(0);
        chk(4'h6, 1);
        per(0);
        chk(4'h6, 14);
        put(cks_pkg::IDX_CLOCK_CONTROL_TWO, 8'hc8);
        wid(1);
        chk(4'h6, 1);
        per(1);
        chk(4'h6, 10);
        chk(4'h2, 0);
        get(cks_pkg::IDX_CLOCK_STATUS, 8'h1b);
        put(cks_pkg::IDX_CLOCK_CONTROL_TWO, 8'h80);
        per(0);
        chk(4'h6, 10);
        chk(4'h2, 0);
        put(cks_pkg::IDX_CLOCK_CONTROL_TWO, 8'h00);
        per(0);
        chk(4'h6, 6);
        chk(4'h2, 1);
        $display("clock switch done");
        modu(3'h3, 5'h00);
        modu(3'h2, 5'h05);
        modu(3'h0, 5'h1f);
        modu(3'h7, 5'h09);
        v = rnd();
        modu(v[2:0], v[7:3]);
        $display("modulation done");
        put(cks_pkg::IDX_CLOCK_CONTROL_ONE, 8'h30);
        put(cks_pkg::IDX_CLOCK_CONTROL_TWO, 8'h01);
        @(posedge clk);
        power_up_clear <= 1'b1;
        @(posedge clk);
        power_up_clear <= 1'b0;
        get(cks_pkg::IDX_CLOCK_CONTROL_ONE, 8'h37);
        get(cks_pkg::IDX_OSC_TUNING, 8'h60);
        get(cks_pkg::IDX_CLOCK_CONTROL_TWO, 8'h00);
        get(cks_pkg::IDX_CLOCK_CONTROL_THREE, 8'h05);
        $display("power-up clear done");
        test_done();
    end
endmodule
`default_nettype wire
